// ---- nmt_cfg.svh ----
// Constants for the network-management state control block
`ifndef NMT_CFG_SVH
`define NMT_CFG_SVH

// -----------------------------------------------------------------
// Frame identifiers and identifier bases
// -----------------------------------------------------------------
`define NMT_ID 11'h000
`define SYNC_ID 11'h080
`define TIME_ID 11'h100
`define EMCY_BASE 11'h080
`define TPDO_BASE 11'h180
`define SDO_TX_BASE 11'h580
`define SDO_RX_BASE 11'h600
`define BOOT_BASE 11'h700

// -----------------------------------------------------------------
// Command bytes and special node values
// -----------------------------------------------------------------
`define CMD_START 8'h01
`define CMD_STOP 8'h02
`define CMD_PREOP 8'h80
`define CMD_RESET_NODE 8'h81
`define CMD_RESET_COMM 8'h82
`define NODE_ALL 8'h00
`define NODE_LSS 8'hff

// -----------------------------------------------------------------
// Reply contents
// -----------------------------------------------------------------
`define SDO_ABORT_CMD 8'h80
`define SDO_ABORT_CODE 32'h08000022
`define EMCY_WARN_CODE 16'hff00
`define EMCY_ERR_REG 8'h01
`define BOOT_DATA 8'h00
`define LEN_BOOT 4'h1
`define LEN_SYNC 4'h4
`define LEN_SDO 4'h8

`endif

// ---- nmt_pkg.sv ----
// Types shared by the network-management state control block
`default_nettype none
package nmt_pkg;
   // Gray codes along initialising, pre-operational, operational, stopped
   typedef enum logic [1:0]
   {
      ST_INIT = 2'b00,
      ST_PREOP = 2'b01,
      ST_OPER = 2'b11,
      ST_STOP = 2'b10
   } nmt_state_t;
endpackage
`default_nettype wire

// ---- sync_skip_counter.sv ----
// Counter that lets a configured number of sync frames pass between replies
`timescale 1ns/1ns
`default_nettype none
module sync_skip_counter
#(
   parameter int WIDTH = 8
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic sync_i,
   input wire logic clear_i,
   input wire logic [WIDTH-1:0] skip_i,
   output logic fire_o
);
   logic [WIDTH-1:0] cnt_reg;
   logic [WIDTH-1:0] cnt_next;

   // Reply on the sync that ends a run of skipped ones
   assign fire_o = sync_i && (cnt_reg >= skip_i);
   assign cnt_next = clear_i ? '0 : (fire_o ? '0 : (sync_i ? cnt_reg + 1'b1 : cnt_reg));

   // Skip count register
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         cnt_reg <= '0;
      else
         cnt_reg <= cnt_next;
   end
endmodule // sync_skip_counter
`default_nettype wire

// ---- canopen_nmt_state_control.sv ----
// Network-management state control for a safety position sensor
//
// Operation
// R1 - Power-up enters pre-operational after sending boot-up frame on 700h plus node.
// R2 - Pre-operational sends and accepts no safety position message.
// R3 - Command 80h to addressed node enters pre-operational.
// R4 - Command 01h to addressed node enters operational.
// R5 - Command 02h to addressed node enters stopped.
// R6 - Target node zero addresses all; own number addresses only this device.
// R7 - 82h resets communication, 81h resets node; both reboot to pre-operational.
// R8 - Safety function and safety messages active only in operational.
// R9 - No safety message unless safety configuration is marked valid.
// R10 - Operational SDO writes to safety objects aborted with 08000022h; reads served.
// R11 - Pre-operational accepts SDO reads and writes to safety objects.
// R12 - Each service is gated by the state table.
// R13 - Layer-setting service active when stopped or node number is FFh.
// R14 - Sync frame answered with current process value, without offset delay.
// R15 - Sync counter skips a configured number of syncs between replies.
// R16 - Configuration valid may be set only with a matching checksum.
// R17 - Pre-operational reachable via default SDO identifiers.
// R18 - Master checks boot-up identifier and reads identity object; the testbench checks the identifier but sends no identity object read.
// R19 - Master reads back written parameters before marking configuration valid.
// R20 - Address-line mismatch sends warning emergency at start and withholds safety messages; emergency sent only on a start from pre-operational.
// R21 - Commands for other nodes are ignored.
`timescale 1ns/1ns
`default_nettype none
`include "nmt_cfg.svh"
module canopen_nmt_state_control
#(
   parameter int SKIP_W = 8
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] node_id_i,
   input wire logic addr_mismatch_i,
   input wire logic rx_valid_i,
   input wire logic [10:0] rx_id_i,
   input wire logic [63:0] rx_data_i,
   input wire logic rx_sdo_write_i,
   input wire logic rx_sdo_safety_i,
   input wire logic cfg_valid_set_i,
   input wire logic cfg_valid_clr_i,
   input wire logic checksum_ok_i,
   input wire logic [SKIP_W-1:0] sync_skip_i,
   input wire logic [31:0] process_value_i,
   input wire logic tx_ready_i,
   output logic tx_valid_o,
   output logic [10:0] tx_id_o,
   output logic [3:0] tx_len_o,
   output logic [63:0] tx_data_o,
   output logic [1:0] state_o,
   output logic cfg_valid_o,
   output logic safety_func_en_o,
   output logic srdo_tx_en_o,
   output logic srdo_rx_en_o,
   output logic pdo_en_o,
   output logic sdo_en_o,
   output logic sync_en_o,
   output logic time_en_o,
   output logic emcy_en_o,
   output logic lss_en_o,
   output logic sdo_fwd_o,
   output logic time_fwd_o,
   output logic comm_reset_o,
   output logic node_reset_o
);
   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   nmt_pkg::nmt_state_t state_reg;
   nmt_pkg::nmt_state_t state_next;
   logic cfg_valid_reg;
   logic cfg_valid_next;
   logic boot_sent_reg;
   logic boot_sent_next;
   logic abort_pend_reg;
   logic abort_pend_next;
   logic emcy_pend_reg;
   logic emcy_pend_next;
   logic sync_pend_reg;
   logic sync_pend_next;
   logic [23:0] abort_mux_reg;
   logic [31:0] sync_val_reg;
   logic tx_valid_reg;
   logic [10:0] tx_id_reg;
   logic [3:0] tx_len_reg;
   logic [63:0] tx_data_reg;
   logic comm_reset_reg;
   logic node_reset_reg;
   logic [10:0] node_ext;
   logic in_preop;
   logic in_oper;
   logic in_stop;
   logic nmt_frame;
   logic nmt_addressed;
   logic nmt_take;
   logic [7:0] nmt_cmd;
   logic [7:0] nmt_target;
   logic cmd_start;
   logic cmd_stop;
   logic cmd_preop;
   logic cmd_rnode;
   logic cmd_rcomm;
   logic sdo_frame;
   logic sdo_refuse;
   logic sync_frame;
   logic sync_fire;
   logic go_oper;
   logic tx_free;
   logic load_boot;
   logic load_abort;
   logic load_emcy;
   logic load_sync;
   logic tx_done;

   // -----------------------------------------------------------------
   // State decode and service gating
   // -----------------------------------------------------------------
   // Enables are combinational levels of the state register, the configuration flag, the address mismatch input and the node number
   assign in_preop = (state_reg == nmt_pkg::ST_PREOP);
   assign in_oper = (state_reg == nmt_pkg::ST_OPER);
   assign in_stop = (state_reg == nmt_pkg::ST_STOP);
   assign node_ext = {3'h0, node_id_i};
   assign safety_func_en_o = in_oper; // see R8
   assign srdo_tx_en_o = in_oper && cfg_valid_reg && !addr_mismatch_i; // see R8 see R9 see R20
   assign srdo_rx_en_o = in_oper && cfg_valid_reg; // see R2 see R8
   assign pdo_en_o = in_oper; // see R12
   assign sdo_en_o = in_preop || in_oper; // see R12
   assign sync_en_o = in_preop || in_oper; // see R12
   assign time_en_o = in_preop || in_oper; // see R12
   assign emcy_en_o = in_preop || in_oper; // see R12
   assign lss_en_o = in_stop || (node_id_i == `NODE_LSS); // see R13
   assign state_o = state_reg;
   assign cfg_valid_o = cfg_valid_reg;

   // -----------------------------------------------------------------
   // Command decode
   // -----------------------------------------------------------------
   // Commands are taken in every state except initialising
   assign nmt_cmd = rx_data_i[7:0];
   assign nmt_target = rx_data_i[15:8];
   assign nmt_frame = rx_valid_i && (rx_id_i == `NMT_ID);
   assign nmt_addressed = (nmt_target == `NODE_ALL) || (nmt_target == node_id_i); // see R6 see R21
   assign nmt_take = nmt_frame && nmt_addressed && (state_reg != nmt_pkg::ST_INIT); // see R12
   assign cmd_start = nmt_take && (nmt_cmd == `CMD_START);
   assign cmd_stop = nmt_take && (nmt_cmd == `CMD_STOP);
   assign cmd_preop = nmt_take && (nmt_cmd == `CMD_PREOP);
   assign cmd_rnode = nmt_take && (nmt_cmd == `CMD_RESET_NODE);
   assign cmd_rcomm = nmt_take && (nmt_cmd == `CMD_RESET_COMM);
   assign go_oper = cmd_start && in_preop;

   // Default SDO channel and time stamp are forwarded only when allowed
   assign sdo_frame = rx_valid_i && (rx_id_i == `SDO_RX_BASE + node_ext) && sdo_en_o; // see R17
   assign sdo_refuse = sdo_frame && in_oper && rx_sdo_write_i && rx_sdo_safety_i; // see R10
   assign sdo_fwd_o = sdo_frame && !sdo_refuse; // see R11
   assign time_fwd_o = rx_valid_i && (rx_id_i == `TIME_ID) && time_en_o; // see R12
   assign sync_frame = rx_valid_i && (rx_id_i == `SYNC_ID) && sync_en_o;

   // Sync skip counter, restarted by either reset
   sync_skip_counter #(.WIDTH(SKIP_W)) u_sync_skip
   (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .sync_i(sync_frame),
      .clear_i(cmd_rnode || cmd_rcomm),
      .skip_i(sync_skip_i),
      .fire_o(sync_fire) // see R15
   );

   // -----------------------------------------------------------------
   // State transitions
   // -----------------------------------------------------------------
   // Resets win over the other commands; boot-up ends initialising
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         nmt_pkg::ST_INIT:
            if (boot_sent_reg)
               state_next = nmt_pkg::ST_PREOP; // see R1
         nmt_pkg::ST_PREOP,
         nmt_pkg::ST_OPER,
         nmt_pkg::ST_STOP:
            if (cmd_rnode || cmd_rcomm)
               state_next = nmt_pkg::ST_INIT; // see R7
            else if (cmd_preop)
               state_next = nmt_pkg::ST_PREOP; // see R3
            else if (cmd_start)
               state_next = nmt_pkg::ST_OPER; // see R4
            else if (cmd_stop)
               state_next = nmt_pkg::ST_STOP; // see R5
      endcase
   end

   // -----------------------------------------------------------------
   // Transmit arbitration
   // -----------------------------------------------------------------
   // One frame at a time; boot-up first, then abort, emergency, sync reply
   assign tx_free = !tx_valid_reg;
   assign tx_done = tx_valid_reg && tx_ready_i;
   assign load_boot = tx_free && (state_reg == nmt_pkg::ST_INIT) && !boot_sent_reg; // see R1 see R12
   assign load_abort = tx_free && !load_boot && abort_pend_reg;
   assign load_emcy = tx_free && !load_boot && !abort_pend_reg && emcy_pend_reg;
   assign load_sync = tx_free && !load_boot && !abort_pend_reg && !emcy_pend_reg && sync_pend_reg;

   // Pending flags: a new event in the loading cycle is kept
   assign boot_sent_next = (state_reg == nmt_pkg::ST_INIT) && (boot_sent_reg || (tx_done && !boot_sent_reg));
   assign abort_pend_next = (abort_pend_reg && !load_abort) || sdo_refuse; // see R10
   assign emcy_pend_next = (emcy_pend_reg && !load_emcy) || (go_oper && addr_mismatch_i); // see R20
   assign sync_pend_next = (sync_pend_reg && !load_sync) || sync_fire; // see R14

   // Configuration valid: set only with a good checksum, set beats clear
   assign cfg_valid_next = (cfg_valid_set_i && checksum_ok_i) || (cfg_valid_reg && !cfg_valid_clr_i && !cmd_rnode); // see R16

   // State, flags and reset pulses
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= nmt_pkg::ST_INIT;
         cfg_valid_reg <= 1'b0;
         boot_sent_reg <= 1'b0;
         abort_pend_reg <= 1'b0;
         emcy_pend_reg <= 1'b0;
         sync_pend_reg <= 1'b0;
         comm_reset_reg <= 1'b0;
         node_reset_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cfg_valid_reg <= cfg_valid_next;
         boot_sent_reg <= boot_sent_next;
         abort_pend_reg <= abort_pend_next && !(cmd_rnode || cmd_rcomm);
         emcy_pend_reg <= emcy_pend_next && !(cmd_rnode || cmd_rcomm);
         sync_pend_reg <= sync_pend_next && !(cmd_rnode || cmd_rcomm);
         comm_reset_reg <= cmd_rcomm; // see R7
         node_reset_reg <= cmd_rnode; // see R7
      end
   end

   // Captured index bytes of a refused request and the sampled process value
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         abort_mux_reg <= 24'h000000;
         sync_val_reg <= 32'h00000000;
      end
      else
      begin
         if (sdo_refuse)
            abort_mux_reg <= rx_data_i[31:8];
         if (sync_fire)
            sync_val_reg <= process_value_i; // see R14
      end
   end

   // Transmit frame register
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         tx_valid_reg <= 1'b0;
         tx_id_reg <= 11'h000;
         tx_len_reg <= 4'h0;
         tx_data_reg <= 64'h0000000000000000;
      end
      else if (load_boot)
      begin
         tx_valid_reg <= 1'b1;
         tx_id_reg <= `BOOT_BASE + node_ext; // see R1
         tx_len_reg <= `LEN_BOOT;
         tx_data_reg <= {56'h0, `BOOT_DATA};
      end
      else if (load_abort)
      begin
         tx_valid_reg <= 1'b1;
         tx_id_reg <= `SDO_TX_BASE + node_ext;
         tx_len_reg <= `LEN_SDO;
         tx_data_reg <= {`SDO_ABORT_CODE, abort_mux_reg, `SDO_ABORT_CMD}; // see R10
      end
      else if (load_emcy)
      begin
         tx_valid_reg <= 1'b1;
         tx_id_reg <= `EMCY_BASE + node_ext;
         tx_len_reg <= `LEN_SDO;
         tx_data_reg <= {40'h0, `EMCY_ERR_REG, `EMCY_WARN_CODE}; // see R20
      end
      else if (load_sync)
      begin
         tx_valid_reg <= 1'b1;
         tx_id_reg <= `TPDO_BASE + node_ext;
         tx_len_reg <= `LEN_SYNC;
         tx_data_reg <= {32'h0, sync_val_reg}; // see R14
      end
      else if (tx_done)
         tx_valid_reg <= 1'b0;
   end

   assign tx_valid_o = tx_valid_reg;
   assign tx_id_o = tx_id_reg;
   assign tx_len_o = tx_len_reg;
   assign tx_data_o = tx_data_reg;
   assign comm_reset_o = comm_reset_reg;
   assign node_reset_o = node_reset_reg;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_safe_write;
      sdo_frame && in_oper && rx_sdo_write_i && rx_sdo_safety_i;
   endsequence

   sequence s_abort_queued;
      !sdo_fwd_o ##1 abort_pend_reg;
   endsequence

   a_boot_frame_id: assert property (load_boot
      |=> tx_valid_o && tx_id_o == `BOOT_BASE + node_ext && tx_len_o == `LEN_BOOT) else $error("boot-up identifier wrong"); // see R1
   a_boot_then_preop: assert property (state_reg == nmt_pkg::ST_INIT && boot_sent_reg
      |=> state_reg == nmt_pkg::ST_PREOP) else $error("no pre-operational after boot-up"); // see R1
   a_preop_no_safety: assert property (in_preop |-> !srdo_tx_en_o && !srdo_rx_en_o)
      else $error("safety messages enabled in pre-operational"); // see R2
   a_cmd_preop: assert property (cmd_preop && !cmd_rnode |=> in_preop)
      else $error("pre-operational command not obeyed"); // see R3 see R6
   a_cmd_start: assert property (nmt_frame && nmt_cmd == `CMD_START
      && (nmt_target == `NODE_ALL || nmt_target == node_id_i)
      && state_reg != nmt_pkg::ST_INIT |=> in_oper) else $error("start command not obeyed"); // see R4 see R6
   a_cmd_stop: assert property (cmd_stop |=> in_stop) else $error("stop command not obeyed"); // see R5
   a_foreign_node: assert property (nmt_frame && nmt_target != `NODE_ALL && nmt_target != node_id_i
      && state_reg != nmt_pkg::ST_INIT |=> $stable(state_reg)) else $error("foreign command changed state"); // see R21
   a_reset_reboot: assert property (cmd_rnode || cmd_rcomm
      |=> state_reg == nmt_pkg::ST_INIT && (node_reset_o || comm_reset_o)) else $error("reset did not reboot"); // see R7
   a_srdo_gate: assert property (srdo_tx_en_o |-> in_oper && cfg_valid_o && !addr_mismatch_i)
      else $error("safety message enabled outside its conditions"); // see R8 see R9 see R20
   a_safe_write_abort: assert property (s_safe_write |-> s_abort_queued)
      else $error("safety write not refused"); // see R10
   a_preop_sdo: assert property (sdo_frame && in_preop |-> sdo_fwd_o)
      else $error("pre-operational SDO not served"); // see R11 see R17
   a_service_gate: assert property (!in_oper |-> !pdo_en_o && (in_preop
      || !(sdo_en_o || sync_en_o || time_en_o || emcy_en_o || sdo_fwd_o || time_fwd_o || sync_fire)))
      else $error("service gating wrong"); // see R12
   a_lss_gate: assert property (lss_en_o == (state_reg == nmt_pkg::ST_STOP || node_id_i == `NODE_LSS))
      else $error("layer setting enabled wrongly"); // see R13
   a_sync_reply: assert property (sync_fire |=> sync_pend_reg && sync_val_reg == $past(process_value_i))
      else $error("sync reply not queued"); // see R14 see R15
   a_cfg_checksum: assert property ($rose(cfg_valid_o) |-> $past(checksum_ok_i) && $past(cfg_valid_set_i))
      else $error("configuration valid without checksum"); // see R16
   a_mismatch_emcy: assert property (go_oper && addr_mismatch_i |=> emcy_pend_reg || tx_id_o == `EMCY_BASE + node_ext)
      else $error("mismatch emergency missing"); // see R20
endmodule // canopen_nmt_state_control
`default_nettype wire

// ---- canopen_master_model.sv ----
// Bus master model: sends frames to the block and accepts the frames it sends
`timescale 1ns/1ns
`default_nettype none
module canopen_master_model
(
   input wire logic clk_i,
   output logic rx_valid_o,
   output logic [10:0] rx_id_o,
   output logic [63:0] rx_data_o,
   output logic rx_sdo_write_o,
   output logic rx_sdo_safety_o,
   output logic tx_ready_o,
   input wire logic tx_valid_i,
   input wire logic [10:0] tx_id_i,
   input wire logic [3:0] tx_len_i,
   input wire logic [63:0] tx_data_i
);
   // -----------------------------------------------------------------
   // Receive side of the block
   // -----------------------------------------------------------------
   // Idle bus, nothing offered, transmitter not ready
   initial
   begin
      rx_valid_o = 1'b0;
      rx_id_o = 11'h7ff;
      rx_data_o = 64'h0;
      rx_sdo_write_o = 1'b0;
      rx_sdo_safety_o = 1'b0;
      tx_ready_o = 1'b0;
   end

   // One frame for one edge; released lines then show the inverse so stale data never looks valid
   task automatic send(input logic [10:0] id, input logic [63:0] d, input logic wr, input logic sf);
   begin
      @(posedge clk_i);
      #1;
      rx_valid_o = 1'b1;
      rx_id_o = id;
      rx_data_o = d;
      rx_sdo_write_o = wr;
      rx_sdo_safety_o = sf;
      @(posedge clk_i);
      #1;
      rx_valid_o = 1'b0;
      rx_id_o = ~id;
      rx_data_o = ~d;
      rx_sdo_write_o = ~wr;
      rx_sdo_safety_o = ~sf;
   end
   endtask

   // -----------------------------------------------------------------
   // Transmit side of the block
   // -----------------------------------------------------------------
   // Waits for a frame, stalls a while, then takes it at the edge where ready is high
   task automatic recv(input int stall, output logic [10:0] id, output logic [3:0] len,
                       output logic [63:0] d, output logic ok);
      int n;
   begin
      n = 0;
      while (tx_valid_i !== 1'b1 && n < 60)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
      ok = (tx_valid_i === 1'b1);
      id = 11'h0;
      len = 4'h0;
      d = 64'h0;
      if (ok)
      begin
         repeat (stall) @(posedge clk_i);
         #1;
         tx_ready_o = 1'b1;
         @(posedge clk_i);
         id = tx_id_i;
         len = tx_len_i;
         d = tx_data_i;
         #1;
         tx_ready_o = 1'b0;
      end
   end
   endtask
endmodule // canopen_master_model
`default_nettype wire

// ---- canopen_nmt_state_control_tb.sv ----
// Self-checking testbench for the network-management state control block
`timescale 1ns/1ns
`default_nettype none
module canopen_nmt_state_control_tb;
   localparam logic [7:0] NODE = 8'h05;
   logic clk, rst_n, mis, set, clr, ck_ok;
   logic [7:0] nid, skip;
   logic [31:0] pv;
   wire logic rxv, rxw, rxs, txr;
   wire logic [10:0] rxid;
   wire logic [63:0] rxd;
   logic txv, sf, stx, srx, pdo, sdo, syn, tim, emc, lss, sfwd, tfwd, crst, nrst, cfg;
   logic [10:0] txid;
   logic [3:0] txlen;
   logic [63:0] txd;
   logic [1:0] state;
   logic [10:0] gid;
   logic [3:0] glen;
   logic [63:0] gdat;
   logic gok;
   int err_count, tests_run, cycles, fwd_cnt, time_cnt, nrst_cnt, crst_cnt, replies;

   canopen_nmt_state_control #(.SKIP_W(8)) dut (.clk_i(clk), .rst_n_i(rst_n), .node_id_i(nid),
      .addr_mismatch_i(mis), .rx_valid_i(rxv), .rx_id_i(rxid), .rx_data_i(rxd), .rx_sdo_write_i(rxw),
      .rx_sdo_safety_i(rxs), .cfg_valid_set_i(set), .cfg_valid_clr_i(clr), .checksum_ok_i(ck_ok),
      .sync_skip_i(skip), .process_value_i(pv), .tx_ready_i(txr), .tx_valid_o(txv), .tx_id_o(txid),
      .tx_len_o(txlen), .tx_data_o(txd), .state_o(state), .cfg_valid_o(cfg), .safety_func_en_o(sf),
      .srdo_tx_en_o(stx), .srdo_rx_en_o(srx), .pdo_en_o(pdo), .sdo_en_o(sdo), .sync_en_o(syn),
      .time_en_o(tim), .emcy_en_o(emc), .lss_en_o(lss), .sdo_fwd_o(sfwd), .time_fwd_o(tfwd),
      .comm_reset_o(crst), .node_reset_o(nrst));

   canopen_master_model master (.clk_i(clk), .rx_valid_o(rxv), .rx_id_o(rxid), .rx_data_o(rxd),
      .rx_sdo_write_o(rxw), .rx_sdo_safety_o(rxs), .tx_ready_o(txr), .tx_valid_i(txv), .tx_id_i(txid),
      .tx_len_i(txlen), .tx_data_i(txd));

   // -----------------------------------------------------------------
   // Clock, pulse counters and timeout
   // -----------------------------------------------------------------
   // 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Counts one-cycle pulses and cuts a hang short
   always @(posedge clk)
   begin
      fwd_cnt += (sfwd === 1'b1);
      time_cnt += (tfwd === 1'b1);
      nrst_cnt += (nrst === 1'b1);
      crst_cnt += (crst === 1'b1);
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         give_verdict();
      end
   end

   // -----------------------------------------------------------------
   // Helper tasks
   // -----------------------------------------------------------------
   task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
   begin
      tests_run++;
      if (s !== e)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   end
   endtask

   task automatic give_verdict();
   begin
      if (err_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
   endtask

   task automatic cyc(input int n);
   begin
      repeat (n) @(posedge clk);
      #1;
   end
   endtask

   task automatic nmt(input logic [7:0] cmd, input logic [7:0] tgt);
   begin
      master.send(11'h000, {48'h0, tgt, cmd}, 1'b0, 1'b0);
      cyc(2);
   end
   endtask

   task automatic frame(input int stall, input logic [10:0] id, input logic [3:0] len, input logic [63:0] d);
   begin
      master.recv(stall, gid, glen, gdat, gok);
      check("tx_taken", 64'(gok), 64'h1);
      check("tx_id", 64'(gid), 64'(id));
      check("tx_len", 64'(glen), 64'(len));
      check("tx_data", gdat, d);
   end
   endtask

   task automatic gate(input logic [8:0] e);
   begin
      check("enables", 64'({sf, stx, srx, pdo, sdo, syn, tim, emc, lss}), 64'(e));
   end
   endtask

   task automatic pulse_set(input logic ok);
   begin
      ck_ok = ok;
      set = 1'b1;
      cyc(1);
      set = 1'b0;
      cyc(1);
   end
   endtask

   // -----------------------------------------------------------------
   // Test sequence
   // -----------------------------------------------------------------
   initial
   begin
      {err_count, tests_run, cycles, fwd_cnt, time_cnt, nrst_cnt, crst_cnt, replies} = '0;
      {rst_n, mis, set, clr, ck_ok} = 5'b0;
      nid = NODE;
      skip = 8'h00;
      pv = 32'h1234_5678;
      cyc(2);
      rst_n = 1'b1;
      frame(2, 11'h700 + 11'(NODE), 4'h1, 64'h0);
      cyc(2);
      check("state", 64'(state), 64'h1);
      gate(9'h01e);
      master.send(11'h600 + 11'(NODE), 64'h0000_0010_0060_0323, 1'b1, 1'b1);
      master.send(11'h100, 64'h0, 1'b0, 1'b0);
      cyc(1);
      check("sdo_fwd", 64'(fwd_cnt), 64'h1);
      check("time_fwd", 64'(time_cnt), 64'h1);
      master.send(11'h080, 64'h0, 1'b0, 1'b0);
      frame(0, 11'h180 + 11'(NODE), 4'h4, 64'(pv));
      pulse_set(1'b0);
      check("cfg", 64'(cfg), 64'h0);
      master.send(11'h600 + 11'(NODE), 64'h0000_0000_0060_0340, 1'b0, 1'b1);
      pulse_set(1'b1);
      check("cfg", 64'(cfg), 64'h1);
      nmt(8'h01, NODE + 8'h01);
      check("state", 64'(state), 64'h1);
      nmt(8'h01, NODE);
      check("state", 64'(state), 64'h3);
      gate(9'h1fe);
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      cyc(1);
      check("srdo_tx", 64'(stx), 64'h0);
      pulse_set(1'b1);
      master.send(11'h600 + 11'(NODE), 64'h0000_0000_1234_5623, 1'b1, 1'b1);
      frame(3, 11'h580 + 11'(NODE), 4'h8, 64'h0800_0022_1234_5680);
      check("sdo_fwd", 64'(fwd_cnt), 64'h2);
      master.send(11'h600 + 11'(NODE), 64'h0000_0000_1234_5640, 1'b0, 1'b1);
      cyc(1);
      check("sdo_fwd", 64'(fwd_cnt), 64'h3);
      nmt(8'h02, 8'h00);
      check("state", 64'(state), 64'h2);
      gate(9'h001);
      master.send(11'h080, 64'h0, 1'b0, 1'b0);
      master.send(11'h100, 64'h0, 1'b0, 1'b0);
      cyc(5);
      check("tx_valid", 64'(txv), 64'h0);
      check("time_fwd", 64'(time_cnt), 64'h1);
      nmt(8'h80, NODE);
      check("state", 64'(state), 64'h1);
      mis = 1'b1;
      nmt(8'h01, 8'h00);
      frame(1, 11'h080 + 11'(NODE), 4'h8, 64'h0000_0000_0001_ff00);
      check("srdo_tx", 64'(stx), 64'h0);
      mis = 1'b0;
      nmt(8'h81, NODE);
      check("state", 64'(state), 64'h0);
      check("cfg", 64'(cfg), 64'h0);
      check("node_rst", 64'(nrst_cnt), 64'h1);
      frame(1, 11'h700 + 11'(NODE), 4'h1, 64'h0);
      pulse_set(1'b1);
      skip = 8'h02;
      nmt(8'h82, 8'h00);
      check("comm_rst", 64'(crst_cnt), 64'h1);
      frame(0, 11'h700 + 11'(NODE), 4'h1, 64'h0);
      cyc(2);
      check("state", 64'(state), 64'h1);
      check("cfg", 64'(cfg), 64'h1);
      for (int i = 0; i < 6; i++)
      begin
         pv = 32'h1234_5678 + 32'(i);
         master.send(11'h080, 64'h0, 1'b0, 1'b0);
         cyc(4);
         if (txv === 1'b1)
         begin
            frame(0, 11'h180 + 11'(NODE), 4'h4, 64'(pv));
            replies++;
         end
      end
      check("sync_replies", 64'(replies), 64'h2);
      nid = 8'hff;
      cyc(1);
      check("lss", 64'(lss), 64'h1);
      give_verdict();
   end
endmodule // canopen_nmt_state_control_tb
`default_nettype wire
